// File: rtl/tmc_timer_mode_control.v
// Configuration, mode and control registers of a two-half timer with APB access
//
// Behaviour
// - Global config: 0 one 32-bit timer, 1 32-bit clock counter, 4-7 two 16-bit halves.
// - In 16-bit operation each half's mode comes from its own mode register low bits.
// - Timer mode field: 1 one-shot, 2 periodic, 3 capture, 0 reserved/invalid.
// - Mode bit 3 selects periodic when zero, PWM when one.
// - Mode bit 2 selects edge-count capture when zero, edge-time when one.
// - In 32-bit timer configuration only half A's mode register counts; half B's ignored.
// - In 16-bit configuration each half's mode field controls only that half.
// - Edge field per half: 00 rising, 01 falling, 11 both, 10 reserved.
// - PWM invert bit per half leaves output unchanged at zero, inverts at one.
// - Trigger enable bit per half gates that half's converter trigger output.
// - Control bit 4 enables clock counter counting.
// - Stall enable bit per half allows that half to stall.
// - Enable bit per half: zero idle, one runs or arms capture.
// - Reserved bits read as any value; software preserves them on write.
// - Periodic halves keep counting after time-out; one-shot halves stop.
//
// The APB slave port was decided locally.
`timescale 1ns/100ps
`include "tmc_map.vh"
module tmc_timer_mode_control (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Core and counter side
  input wire debug_halt,
  input wire a_timeout,
  input wire b_timeout,
  input wire a_trigger_raw,
  input wire b_trigger_raw,
  input wire a_pwm_raw,
  input wire b_pwm_raw,
  input wire a_event_in,
  input wire b_event_in,
  // Decoded controls
  output reg a_run,
  output reg b_run,
  output reg clock_count_run,
  output reg [2:0] a_func,
  output reg [2:0] b_func,
  output reg wide_mode,
  output reg a_event_pulse,
  output reg b_event_pulse,
  output reg a_trigger_out,
  output reg b_trigger_out,
  output reg a_pwm_out,
  output reg b_pwm_out,
  // Interrupt
  output reg irq
);

  // Function codes on a_func/b_func
  localparam [2:0] FN_IDLE = 3'h0;
  localparam [2:0] FN_ONE_SHOT = 3'h1;
  localparam [2:0] FN_PERIODIC = 3'h2;
  localparam [2:0] FN_CAP_COUNT = 3'h3;
  localparam [2:0] FN_CAP_TIME = 3'h4;
  localparam [2:0] FN_PWM = 3'h5;
  localparam [2:0] FN_RTC = 3'h6;

  // Per-half run states, one-hot
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  reg [`TMC_CFG_W-1:0] cfg_ff;
  reg [`TMC_MODE_W-1:0] amode_ff;
  reg [`TMC_MODE_W-1:0] bmode_ff;
  reg [31:0] ctl_ff;
  reg [`TMC_IRQ_W-1:0] sts_ff;
  reg [`TMC_IRQ_W-1:0] msk_ff;
  reg [2:0] ast_ff;
  reg [2:0] bst_ff;
  reg a_ev_ff;
  reg b_ev_ff;
  reg [`TMC_IRQ_W-1:0] nxt_sts;
  reg [31:0] nxt_rdata;
  reg [2:0] nxt_ast;
  reg [2:0] nxt_bst;
  reg [2:0] nxt_afunc;
  reg [2:0] nxt_bfunc;

  wire wr_en;
  wire rd_en;
  wire addr_ok;
  wire is_wide;
  wire a_ce;
  wire b_ce;

  // Decode one half's mode nibble into a function code
  function [2:0] mode_fn;
    input [3:0] m;
    begin
      case (m[1:0])
        `TMC_TM_ONE_SHOT: mode_fn = FN_ONE_SHOT;
        `TMC_TM_PERIODIC: mode_fn = m[`TMC_MODE_ALT_SEL] ? FN_PWM : FN_PERIODIC;
        `TMC_TM_CAPTURE: mode_fn = m[`TMC_MODE_CAP_STYLE] ? FN_CAP_TIME : FN_CAP_COUNT;
        default: mode_fn = FN_IDLE;
      endcase
    end
  endfunction

  // Edge detector honouring the two-bit event field
  function edge_hit;
    input [1:0] sel;
    input cur;
    input prev;
    begin
      case (sel)
        `TMC_EDGE_RISE: edge_hit = cur & ~prev;
        `TMC_EDGE_FALL: edge_hit = ~cur & prev;
        `TMC_EDGE_BOTH: edge_hit = cur ^ prev;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  // One-wait APB: every access completes in its second access cycle
  assign wr_en = psel & penable & pwrite & ~pready;
  assign rd_en = psel & penable & ~pwrite & ~pready;
  assign addr_ok = (paddr == `TMC_OFS_GLOBAL_CONFIG) | (paddr == `TMC_OFS_HALF_A_MODE) |
                   (paddr == `TMC_OFS_HALF_B_MODE) | (paddr == `TMC_OFS_TIMER_CONTROL) |
                   (paddr == `TMC_OFS_IRQ_STATUS) | (paddr == `TMC_OFS_IRQ_MASK) |
                   (paddr == `TMC_OFS_STATE);
  assign is_wide = ~cfg_ff[2];
  // Stall gating of each half
  assign a_ce = ~(ctl_ff[`TMC_CTL_A_STALL] & debug_halt);
  assign b_ce = ~(ctl_ff[`TMC_CTL_B_STALL] & debug_halt);

  // Function selection
  always @* begin
    nxt_afunc = FN_IDLE;
    nxt_bfunc = FN_IDLE;
    if (cfg_ff == `TMC_CFG_32_RTC) begin
      nxt_afunc = FN_RTC;
    end else if (cfg_ff == `TMC_CFG_32_TIMER) begin
      nxt_afunc = mode_fn(amode_ff);
    end else if (cfg_ff[2]) begin
      nxt_afunc = mode_fn(amode_ff);
      nxt_bfunc = mode_fn(bmode_ff);
    end
  end

  // Run state of half A; one-shot ends at time-out, periodic continues
  always @* begin
    nxt_ast = ast_ff;
    case (ast_ff)
      ST_IDLE: begin
        if (ctl_ff[`TMC_CTL_A_EN] && nxt_afunc != FN_IDLE && nxt_afunc != FN_RTC) begin
          nxt_ast = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!ctl_ff[`TMC_CTL_A_EN] || nxt_afunc == FN_IDLE) begin
          nxt_ast = ST_IDLE;
        end else if (a_timeout && a_ce && a_func == FN_ONE_SHOT) begin
          nxt_ast = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!ctl_ff[`TMC_CTL_A_EN]) begin
          nxt_ast = ST_IDLE;
        end
      end
      default: nxt_ast = ST_IDLE;
    endcase
  end

  // Run state of half B; only live in 16-bit configuration
  always @* begin
    nxt_bst = bst_ff;
    case (bst_ff)
      ST_IDLE: begin
        if (ctl_ff[`TMC_CTL_B_EN] && nxt_bfunc != FN_IDLE) begin
          nxt_bst = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!ctl_ff[`TMC_CTL_B_EN] || nxt_bfunc == FN_IDLE) begin
          nxt_bst = ST_IDLE;
        end else if (b_timeout && b_ce && b_func == FN_ONE_SHOT) begin
          nxt_bst = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!ctl_ff[`TMC_CTL_B_EN]) begin
          nxt_bst = ST_IDLE;
        end
      end
      default: nxt_bst = ST_IDLE;
    endcase
  end

  // Sticky events: set beats write-one-to-clear in the same cycle
  always @* begin
    nxt_sts = sts_ff;
    if (wr_en && paddr == `TMC_OFS_IRQ_STATUS) begin
      nxt_sts = sts_ff & ~pwdata[`TMC_IRQ_W-1:0];
    end
    nxt_sts = nxt_sts | {b_timeout & b_run, a_timeout & a_run,
                         b_event_pulse, a_event_pulse};
  end

  // Read mux; reserved bits read zero
  always @* begin
    nxt_rdata = `TMC_RST_ZERO;
    case (paddr)
      `TMC_OFS_GLOBAL_CONFIG: nxt_rdata = {29'h0, cfg_ff};
      `TMC_OFS_HALF_A_MODE: nxt_rdata = {28'h0, amode_ff};
      `TMC_OFS_HALF_B_MODE: nxt_rdata = {28'h0, bmode_ff};
      `TMC_OFS_TIMER_CONTROL: nxt_rdata = ctl_ff;
      `TMC_OFS_IRQ_STATUS: nxt_rdata = {28'h0, sts_ff};
      `TMC_OFS_IRQ_MASK: nxt_rdata = {28'h0, msk_ff};
      `TMC_OFS_STATE: nxt_rdata = {26'h0, bst_ff, ast_ff};
      default: nxt_rdata = `TMC_RST_ZERO;
    endcase
  end

  // Configuration and mode; reserved bits are not stored, so preserved values are harmless
  always @(posedge sys_clk) begin
    if (reset) begin
      cfg_ff <= 3'h0;
      amode_ff <= 4'h0;
      bmode_ff <= 4'h0;
    end else if (wr_en) begin
      case (paddr)
        `TMC_OFS_GLOBAL_CONFIG: cfg_ff <= pwdata[`TMC_CFG_W-1:0];
        `TMC_OFS_HALF_A_MODE: amode_ff <= pwdata[`TMC_MODE_W-1:0];
        `TMC_OFS_HALF_B_MODE: bmode_ff <= pwdata[`TMC_MODE_W-1:0];
        default: ;
      endcase
    end
  end

  // Control keeps only its defined bits
  always @(posedge sys_clk) begin
    if (reset) begin
      ctl_ff <= `TMC_RST_ZERO;
    end else if (wr_en && paddr == `TMC_OFS_TIMER_CONTROL) begin
      ctl_ff <= pwdata & `TMC_CTL_MASK;
    end
  end

  // Interrupt mask
  always @(posedge sys_clk) begin
    if (reset) begin
      msk_ff <= 4'h0;
    end else if (wr_en && paddr == `TMC_OFS_IRQ_MASK) begin
      msk_ff <= pwdata[`TMC_IRQ_W-1:0];
    end
  end

  // Bus answer: one access cycle, then a one-cycle pready pulse
  always @(posedge sys_clk) begin
    if (reset) begin
      prdata <= `TMC_RST_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok;
      prdata <= rd_en ? nxt_rdata : `TMC_RST_ZERO;
    end
  end

  // Status and interrupt move together, so irq never lags a set bit
  always @(posedge sys_clk) begin
    if (reset) begin
      sts_ff <= 4'h0;
      irq <= 1'b0;
    end else begin
      sts_ff <= nxt_sts;
      irq <= |(nxt_sts & msk_ff);
    end
  end

  // Half A state and run flag
  always @(posedge sys_clk) begin
    if (reset) begin
      ast_ff <= ST_IDLE;
      a_run <= 1'b0;
    end else begin
      ast_ff <= nxt_ast;
      a_run <= (nxt_ast == ST_RUN) & a_ce;
    end
  end

  // Half B state and run flag
  always @(posedge sys_clk) begin
    if (reset) begin
      bst_ff <= ST_IDLE;
      b_run <= 1'b0;
    end else begin
      bst_ff <= nxt_bst;
      b_run <= (nxt_bst == ST_RUN) & b_ce;
    end
  end

  // Clock counter run
  always @(posedge sys_clk) begin
    if (reset) begin
      clock_count_run <= 1'b0;
    end else begin
      clock_count_run <= (cfg_ff == `TMC_CFG_32_RTC) & ctl_ff[`TMC_CTL_CLK_CNT_EN];
    end
  end

  // Decoded function codes and width flag
  always @(posedge sys_clk) begin
    if (reset) begin
      a_func <= FN_IDLE;
      b_func <= FN_IDLE;
      wide_mode <= 1'b1;
    end else begin
      a_func <= nxt_afunc;
      b_func <= nxt_bfunc;
      wide_mode <= is_wide;
    end
  end

  // Half A capture edges; history starts low to match an idle input
  always @(posedge sys_clk) begin
    if (reset) begin
      a_ev_ff <= 1'b0;
      a_event_pulse <= 1'b0;
    end else begin
      a_ev_ff <= a_event_in;
      a_event_pulse <= (ast_ff == ST_RUN) &
                       edge_hit(ctl_ff[`TMC_CTL_A_EDGE_LO+1:`TMC_CTL_A_EDGE_LO],
                                a_event_in, a_ev_ff);
    end
  end

  // Half B capture edges
  always @(posedge sys_clk) begin
    if (reset) begin
      b_ev_ff <= 1'b0;
      b_event_pulse <= 1'b0;
    end else begin
      b_ev_ff <= b_event_in;
      b_event_pulse <= (bst_ff == ST_RUN) &
                       edge_hit(ctl_ff[`TMC_CTL_B_EDGE_LO+1:`TMC_CTL_B_EDGE_LO],
                                b_event_in, b_ev_ff);
    end
  end

  // Half A trigger and PWM outputs
  always @(posedge sys_clk) begin
    if (reset) begin
      a_trigger_out <= 1'b0;
      a_pwm_out <= 1'b0;
    end else begin
      a_trigger_out <= a_trigger_raw & ctl_ff[`TMC_CTL_A_TRIG];
      a_pwm_out <= a_pwm_raw ^ ctl_ff[`TMC_CTL_A_PWM_INV];
    end
  end

  // Half B trigger and PWM outputs
  always @(posedge sys_clk) begin
    if (reset) begin
      b_trigger_out <= 1'b0;
      b_pwm_out <= 1'b0;
    end else begin
      b_trigger_out <= b_trigger_raw & ctl_ff[`TMC_CTL_B_TRIG];
      b_pwm_out <= b_pwm_raw ^ ctl_ff[`TMC_CTL_B_PWM_INV];
    end
  end

endmodule // tmc_timer_mode_control

// File: rtl/tmc_map.vh
// Register offsets, field positions and reset values of the timer mode control block
`ifndef TMC_MAP_VH
`define TMC_MAP_VH
`define TMC_OFS_GLOBAL_CONFIG 12'h000
`define TMC_OFS_HALF_A_MODE 12'h004
`define TMC_OFS_HALF_B_MODE 12'h008
`define TMC_OFS_TIMER_CONTROL 12'h00C
`define TMC_OFS_IRQ_STATUS 12'h010
`define TMC_OFS_IRQ_MASK 12'h014
`define TMC_OFS_STATE 12'h040
`define TMC_RST_ZERO 32'h00000000
`define TMC_CFG_W 3
`define TMC_MODE_W 4
`define TMC_CTL_MASK 32'h00006F7F
`define TMC_CFG_32_TIMER 3'h0
`define TMC_CFG_32_RTC 3'h1
`define TMC_TM_ONE_SHOT 2'h1
`define TMC_TM_PERIODIC 2'h2
`define TMC_TM_CAPTURE 2'h3
`define TMC_MODE_CAP_STYLE 2
`define TMC_MODE_ALT_SEL 3
`define TMC_CTL_A_EN 0
`define TMC_CTL_A_STALL 1
`define TMC_CTL_A_EDGE_LO 2
`define TMC_CTL_CLK_CNT_EN 4
`define TMC_CTL_A_TRIG 5
`define TMC_CTL_A_PWM_INV 6
`define TMC_CTL_B_EN 8
`define TMC_CTL_B_STALL 9
`define TMC_CTL_B_EDGE_LO 10
`define TMC_CTL_B_TRIG 13
`define TMC_CTL_B_PWM_INV 14
`define TMC_EDGE_RISE 2'h0
`define TMC_EDGE_FALL 2'h1
`define TMC_EDGE_BOTH 2'h3
`define TMC_IRQ_W 4
`endif

// File: bench/tmc_assertions.sv
// Port-level assertion checker for the timer mode control block
`timescale 1ns/100ps
module tmc_checker (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // Bus
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire [31:0] prdata,
  // Side signals
  input wire a_trigger_raw,
  input wire a_trigger_out,
  input wire a_event_in,
  input wire a_event_pulse,
  input wire a_run,
  input wire [2:0] a_func,
  input wire [2:0] b_func,
  input wire wide_mode,
  input wire clock_count_run
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  AST_READY_PULSE:
    assert property (pready |=> !pready) else $error("pready longer than one cycle");
  AST_READY_LATENCY:
    assert property (psel && penable && !pready |=> pready) else $error("pready late");
  AST_ERR_WITH_READY:
    assert property (pslverr |-> pready) else $error("pslverr without pready");
  AST_RDATA_QUIET:
    assert property (!pready |-> prdata == 32'h0) else $error("prdata outside answer");
  AST_A_TRIGGER:
    assert property (a_trigger_out |-> $past(a_trigger_raw)) else $error("trigger without raw");
  AST_B_IDLE_WIDE:
    assert property (wide_mode |-> b_func == 3'h0) else $error("half B active in wide mode");
  AST_CLOCK_WIDE:
    assert property (clock_count_run |-> wide_mode && a_func == 3'h6) else $error("clock run");
  AST_FUNC_CODES:
    assert property (a_func <= 3'h6 && b_func <= 3'h5) else $error("function code out of range");
  AST_RUN_VALID:
    assert property (a_run |-> a_func != 3'h0) else $error("half A runs with no function");
  AST_EVENT_EDGE:
    assert property (a_event_pulse |-> $past(a_event_in) != $past(a_event_in, 2))
      else $error("event pulse without edge");
endmodule // tmc_checker

bind tmc_timer_mode_control tmc_checker u_tmc_checker (.sys_clk(sys_clk), .reset(reset),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .a_trigger_raw(a_trigger_raw), .a_trigger_out(a_trigger_out), .a_event_in(a_event_in),
  .a_event_pulse(a_event_pulse), .a_run(a_run), .a_func(a_func), .b_func(b_func),
  .wide_mode(wide_mode), .clock_count_run(clock_count_run));

// File: bench/tmc_timer_mode_control_test.sv
// Self-checking bench for the timer mode control block
`timescale 1ns/100ps
`include "tmc_map.vh"
module tmc_timer_mode_control_test;
  logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, debug_halt, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic a_timeout, b_timeout, a_trigger_raw, b_trigger_raw, a_pwm_raw, b_pwm_raw;
  logic a_event_in, b_event_in, a_run, b_run, clock_count_run, wide_mode, er;
  logic a_event_pulse, b_event_pulse, a_trigger_out, b_trigger_out, a_pwm_out, b_pwm_out;
  logic [2:0] a_func, b_func;
  int mismatches, total_checks, pulses, bpulses, p0, q0;
  logic [18:0] outs;
  assign outs = {pready, pslverr, a_run, b_run, clock_count_run, a_func, b_func, wide_mode,
    a_event_pulse, b_event_pulse, a_trigger_out, b_trigger_out, a_pwm_out, b_pwm_out, irq};
  // Row: config, A mode, B mode, expected A function, expected B function
  logic [19:0] rows [11] = '{20'h01210, 20'h00300, 20'h02120, 20'h11160, 20'h21100,
    20'h32200, 20'h41212, 20'h53734, 20'h6A050, 20'h70A05, 20'h40303};
  // Edge code beside pulses expected for one rise and one fall
  logic [7:0] edges [4] = '{8'h01, 8'h11, 8'h32, 8'h20};

  tmc_timer_mode_control u_tmc_timer_mode_control (.sys_clk(sys_clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .debug_halt(debug_halt),
    .a_timeout(a_timeout), .b_timeout(b_timeout), .a_trigger_raw(a_trigger_raw),
    .b_trigger_raw(b_trigger_raw), .a_pwm_raw(a_pwm_raw), .b_pwm_raw(b_pwm_raw),
    .a_event_in(a_event_in), .b_event_in(b_event_in), .a_run(a_run), .b_run(b_run),
    .clock_count_run(clock_count_run), .a_func(a_func), .b_func(b_func),
    .wide_mode(wide_mode), .a_event_pulse(a_event_pulse), .b_event_pulse(b_event_pulse),
    .a_trigger_out(a_trigger_out), .b_trigger_out(b_trigger_out), .a_pwm_out(a_pwm_out),
    .b_pwm_out(b_pwm_out), .irq(irq));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (a_event_pulse === 1'b1) pulses <= pulses + 1;
    if (b_event_pulse === 1'b1) bpulses <= bpulses + 1;
  end

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request held until pready is sampled; no fixed latency assumed
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      complete_run();
    end
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(string nm, logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  initial begin
    {psel, penable, pwrite, debug_halt, a_timeout, b_timeout} = 6'h0;
    {a_trigger_raw, b_trigger_raw, a_pwm_raw, b_pwm_raw, a_event_in, b_event_in} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    reset = 1'b1;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    chk("outputs at reset", 32'h80, 32'(outs));
    for (int i = 0; i < 4; i++) rdc("reset value", 12'(4 * i), 32'h0);
    foreach (rows[i]) begin
      wr(`TMC_OFS_GLOBAL_CONFIG, 32'(rows[i][19:16]));
      wr(`TMC_OFS_HALF_A_MODE, 32'(rows[i][15:12]));
      wr(`TMC_OFS_HALF_B_MODE, 32'(rows[i][11:8]));
      repeat (2) @(posedge sys_clk);
      chk("a_func", 32'(rows[i][7:4]), 32'(a_func));
      chk("b_func", 32'(rows[i][3:0]), 32'(b_func));
      chk("wide_mode", 32'(rows[i][19:16] < 4), 32'(wide_mode));
      rdc("half_b_mode", `TMC_OFS_HALF_B_MODE, 32'(rows[i][11:8]));
    end
    apb(1'b1, 12'h030, 32'hFFFFFFFF);
    chk("unmapped write error", 32'h1, 32'(er));
    apb(1'b0, 12'h030, 32'h0);
    chk("unmapped read error", 32'h1, 32'(er));
    // Reserved bits go back as they were read
    a_trigger_raw <= 1'b1;
    b_trigger_raw <= 1'b1;
    rdc("timer_control idle", `TMC_OFS_TIMER_CONTROL, 32'h0);
    wr(`TMC_OFS_TIMER_CONTROL, (rd & ~`TMC_CTL_MASK) | 32'h00004020);
    rdc("timer_control", `TMC_OFS_TIMER_CONTROL, 32'h00004020);
    chk("a_trigger_out", 32'h1, 32'(a_trigger_out));
    chk("b_trigger_out", 32'h0, 32'(b_trigger_out));
    chk("pwm out", 32'h1, 32'({a_pwm_out, b_pwm_out}));
    a_pwm_raw <= 1'b1;
    b_pwm_raw <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("pwm out raised", 32'h2, 32'({a_pwm_out, b_pwm_out}));
    wr(`TMC_OFS_TIMER_CONTROL, 32'h0);
    wr(`TMC_OFS_GLOBAL_CONFIG, 32'h1);
    wr(`TMC_OFS_TIMER_CONTROL, 32'h10);
    repeat (2) @(posedge sys_clk);
    chk("clock_count_run on", 32'h1, 32'(clock_count_run));
    wr(`TMC_OFS_TIMER_CONTROL, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk("clock_count_run off", 32'h0, 32'(clock_count_run));
    wr(`TMC_OFS_GLOBAL_CONFIG, 32'h4);
    wr(`TMC_OFS_HALF_A_MODE, 32'h1);
    wr(`TMC_OFS_HALF_B_MODE, 32'h2);
    wr(`TMC_OFS_IRQ_MASK, 32'h4);
    wr(`TMC_OFS_TIMER_CONTROL, 32'h0303);
    repeat (3) @(posedge sys_clk);
    chk("runs enabled", 32'h3, 32'({a_run, b_run}));
    debug_halt <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("runs stalled", 32'h0, 32'({a_run, b_run}));
    debug_halt <= 1'b0;
    repeat (3) @(posedge sys_clk);
    a_timeout <= 1'b1;
    b_timeout <= 1'b1;
    @(posedge sys_clk);
    a_timeout <= 1'b0;
    b_timeout <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("runs after time-out", 32'h1, 32'({a_run, b_run}));
    rdc("run state", `TMC_OFS_STATE, 32'h14);
    chk("irq raised", 32'h1, 32'(irq));
    rdc("irq status", `TMC_OFS_IRQ_STATUS, 32'hC);
    wr(`TMC_OFS_IRQ_STATUS, 32'h4);
    repeat (2) @(posedge sys_clk);
    chk("irq cleared", 32'h0, 32'(irq));
    rdc("irq status left", `TMC_OFS_IRQ_STATUS, 32'h8);
    wr(`TMC_OFS_TIMER_CONTROL, 32'h0);
    wr(`TMC_OFS_HALF_A_MODE, 32'h3);
    wr(`TMC_OFS_HALF_B_MODE, 32'h3);
    // Halt held across the loop; with stall off both halves keep running
    debug_halt <= 1'b1;
    foreach (edges[i]) begin
      wr(`TMC_OFS_TIMER_CONTROL, 32'h0);
      wr(`TMC_OFS_TIMER_CONTROL, (32'(edges[i][7:4]) * 32'h404) | 32'h101);
      repeat (3) @(posedge sys_clk);
      chk("runs without stall", 32'h3, 32'({a_run, b_run}));
      p0 = pulses;
      q0 = bpulses;
      a_event_in <= 1'b1;
      b_event_in <= 1'b1;
      repeat (3) @(posedge sys_clk);
      a_event_in <= 1'b0;
      b_event_in <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk("edge pulses", 32'(edges[i][3:0]), 32'(pulses - p0));
      chk("b edge pulses", 32'(edges[i][3:0]), 32'(bpulses - q0));
    end
    debug_halt <= 1'b0;
    // Reset in mid-run returns every output to its idle value
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    chk("outputs after reset", 32'h80, 32'(outs));
    rdc("timer_control after reset", `TMC_OFS_TIMER_CONTROL, 32'h0);
    rdc("half_a_mode after reset", `TMC_OFS_HALF_A_MODE, 32'h0);
    complete_run();
  end
endmodule // tmc_timer_mode_control_test
